// ---- ufc_pkg.sv ----
// Purpose: shared constants and helpers for the dual-channel FIFO control
// Assumes: 32-entry receive and transmit FIFOs per channel, 8-bit control
// Notes:   trigger decode lives here so both channels use the same tables

package ufc_pkg;

  localparam int CNT_W      = 6;
  localparam int FIFO_DEPTH = 32;
  localparam int NUM_CHAN   = 2;

  // register byte offsets on the bus
  localparam logic [3:0] OFS_CTRL0 = 4'h0;
  localparam logic [3:0] OFS_CTRL1 = 4'h4;
  localparam logic [3:0] OFS_STAT0 = 4'h8;
  localparam logic [3:0] OFS_STAT1 = 4'hc;

  // control register field positions
  localparam int CTL_RXTRIG_HI = 7;
  localparam int CTL_RXTRIG_LO = 6;
  localparam int CTL_TXTRIG_HI = 5;
  localparam int CTL_TXTRIG_LO = 4;
  localparam int CTL_DMA       = 3;
  localparam int CTL_TXCLR     = 2;
  localparam int CTL_RXCLR     = 1;
  localparam int CTL_FIFOEN    = 0;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // status register field positions
  localparam int STA_RXRDYN   = 0;
  localparam int STA_TXRDYN   = 1;
  localparam int STA_RXTRIG   = 2;
  localparam int STA_TXBELOW  = 3;
  localparam int STA_RXSPACE  = 4;
  localparam int STA_RXCNT_LO = 8;
  localparam int STA_TXCNT_LO = 16;

  // receive trigger decode
  function automatic logic [CNT_W-1:0] rx_level(input logic [1:0] sel);
    case (sel)
      2'h0:    rx_level = 6'h08;
      2'h1:    rx_level = 6'h10;
      2'h2:    rx_level = 6'h18;
      default: rx_level = 6'h1c;
    endcase
  endfunction

  // transmit trigger decode
  function automatic logic [CNT_W-1:0] tx_level(input logic [1:0] sel);
    case (sel)
      2'h0:    tx_level = 6'h10;
      2'h1:    tx_level = 6'h08;
      2'h2:    tx_level = 6'h18;
      default: tx_level = 6'h1e;
    endcase
  endfunction

endpackage

// ---- ufc_channel.sv ----
// Purpose: ready pins and trigger conditions for one channel
// Assumes: occupancy counts come from logic on mclk, no synchroniser
// Notes:   all outputs registered; mode 1 only applies with FIFOs enabled
`timescale 1ns/1ps
`default_nettype none

module ufc_channel #(
  parameter int CW    = ufc_pkg::CNT_W,
  parameter int DEPTH = ufc_pkg::FIFO_DEPTH
) (
  input  wire logic          mclk,
  input  wire logic          rst_b,
  input  wire logic          ce,
  input  wire logic          fifoEnable,
  input  wire logic          dmaMode,
  input  wire logic [1:0]    rxTrigSel,
  input  wire logic [1:0]    txTrigSel,
  input  wire logic [CW-1:0] rxCount,
  input  wire logic [CW-1:0] txCount,
  input  wire logic          rxTimeout,
  output logic               txReadyN,
  output logic               rxReadyN,
  output logic               rxTrigHit,
  output logic               txBelowTrig,
  output logic               rxSpace
);

  logic [CW-1:0] rxLevel;
  logic [CW-1:0] txLevel;
  logic          blockMode;
  logic          txFull;

  // trigger decode and effective mode
  assign rxLevel   = ufc_pkg::rx_level(rxTrigSel);
  assign txLevel   = ufc_pkg::tx_level(txTrigSel);
  assign blockMode = dmaMode & fifoEnable;
  assign txFull    = (txCount >= CW'(DEPTH));

  // interrupt conditions toward the priority logic
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rxTrigHit   <= 1'b0;
      txBelowTrig <= 1'b0;
    end else if (ce) begin
      rxTrigHit   <= fifoEnable & (rxCount >= rxLevel);
      txBelowTrig <= fifoEnable & (txCount < txLevel);
    end
  end

  // receiver may keep loading until completely full
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rxSpace <= 1'b1;
    end else if (ce) begin
      rxSpace <= (rxCount < CW'(DEPTH));
    end
  end

  // transmit ready pin
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      txReadyN <= 1'b0;
    end else if (ce) begin
      if (!blockMode) begin
        txReadyN <= (txCount != '0);
      end else if (txFull) begin
        txReadyN <= 1'b1;
      end else if (txCount <= txLevel) begin
        txReadyN <= 1'b0;
      end
    end
  end

  // receive ready pin
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rxReadyN <= 1'b1;
    end else if (ce) begin
      if (!blockMode) begin
        rxReadyN <= (rxCount == '0);
      end else if (rxCount == '0) begin
        rxReadyN <= 1'b1;
      end else if ((rxCount >= rxLevel) || rxTimeout) begin
        rxReadyN <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ---- ufc_top.sv ----
// Purpose: two-channel FIFO control registers behind a Wishbone slave
// Assumes: classic Wishbone, 32-bit data, byte addresses, one clock
// Notes:   ack comes one cycle after the request, all four word addresses are mapped
//
// Local design decisions: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module ufc_top #(
  parameter int CW    = ufc_pkg::CNT_W,
  parameter int DEPTH = ufc_pkg::FIFO_DEPTH
) (
  input  wire logic          mclk,
  input  wire logic          rst_b,
  input  wire logic          ce,
  // wishbone slave
  input  wire logic          cyc_i,
  input  wire logic          stb_i,
  input  wire logic          we_i,
  input  wire logic [3:0]    adr_i,
  input  wire logic [3:0]    sel_i,
  input  wire logic [31:0]   dat_i,
  output logic [31:0]        dat_o,
  output logic               ack_o,
  // channel 0 fifo side
  input  wire logic [CW-1:0] rxCount0,
  input  wire logic [CW-1:0] txCount0,
  input  wire logic          rxTimeout0,
  output logic               txReadyN0,
  output logic               rxReadyN0,
  output logic               rxTrigHit0,
  output logic               txBelowTrig0,
  output logic               rxSpace0,
  output logic               fifoEnable0,
  output logic               txFifoClear0,
  output logic               rxFifoClear0,
  // channel 1 fifo side
  input  wire logic [CW-1:0] rxCount1,
  input  wire logic [CW-1:0] txCount1,
  input  wire logic          rxTimeout1,
  output logic               txReadyN1,
  output logic               rxReadyN1,
  output logic               rxTrigHit1,
  output logic               txBelowTrig1,
  output logic               rxSpace1,
  output logic               fifoEnable1,
  output logic               txFifoClear1,
  output logic               rxFifoClear1
);

  // per-channel control state, index is the channel
  logic       fifoEn   [2];
  logic       dmaSel   [2];
  logic [1:0] rxTrig   [2];
  logic [1:0] txTrig   [2];
  logic       txClr    [2];
  logic       rxClr    [2];

  // bus decode
  logic        busReq;
  logic        wrDone;
  logic        selCtrl0;
  logic        selCtrl1;
  logic        ctlWr [2];
  logic [7:0]  wrByte;
  logic        wrLane;
  logic [31:0] next_dat;

  // channel outputs gathered for status reads
  logic [CW-1:0] rxCnt [2];
  logic [CW-1:0] txCnt [2];
  logic          txRdyN [2];
  logic          rxRdyN [2];
  logic          rxHit  [2];
  logic          txBelow [2];
  logic          rxRoom [2];

  // build the control byte as software reads it back
  function automatic logic [7:0] ctrl_byte(input logic       en,
                                           input logic       dma,
                                           input logic [1:0] rxt,
                                           input logic [1:0] txt,
                                           input logic       txc,
                                           input logic       rxc);
    ctrl_byte = ufc_pkg::CTL_RESET;
    ctrl_byte[ufc_pkg::CTL_RXTRIG_HI:ufc_pkg::CTL_RXTRIG_LO] = rxt;
    ctrl_byte[ufc_pkg::CTL_TXTRIG_HI:ufc_pkg::CTL_TXTRIG_LO] = txt;
    ctrl_byte[ufc_pkg::CTL_DMA]    = dma;
    ctrl_byte[ufc_pkg::CTL_TXCLR]  = txc;
    ctrl_byte[ufc_pkg::CTL_RXCLR]  = rxc;
    ctrl_byte[ufc_pkg::CTL_FIFOEN] = en;
  endfunction

  // build a status word for one channel
  function automatic logic [31:0] stat_word(input logic          rrn,
                                            input logic          trn,
                                            input logic          rh,
                                            input logic          tb,
                                            input logic          rs,
                                            input logic [CW-1:0] rc,
                                            input logic [CW-1:0] tc);
    stat_word = 32'h0000_0000;
    stat_word[ufc_pkg::STA_RXRDYN]  = rrn;
    stat_word[ufc_pkg::STA_TXRDYN]  = trn;
    stat_word[ufc_pkg::STA_RXTRIG]  = rh;
    stat_word[ufc_pkg::STA_TXBELOW] = tb;
    stat_word[ufc_pkg::STA_RXSPACE] = rs;
    stat_word[ufc_pkg::STA_RXCNT_LO +: CW] = rc;
    stat_word[ufc_pkg::STA_TXCNT_LO +: CW] = tc;
  endfunction

  // true when the word part of a byte address matches an offset
  function automatic logic word_hit(input logic [3:0] adr,
                                    input logic [3:0] ofs);
    word_hit = ({adr[3:2], 2'b00} == ofs);
  endfunction

  // request qualification; the write lands on the edge that sees ack
  assign busReq   = cyc_i & stb_i;
  assign wrDone   = busReq & we_i & ack_o;
  assign wrLane   = sel_i[0];
  assign wrByte   = dat_i[7:0];

  // address decode for the writable registers
  always_comb begin
    selCtrl0 = 1'b0;
    selCtrl1 = 1'b0;
    if (word_hit(adr_i, ufc_pkg::OFS_CTRL0)) begin
      selCtrl0 = 1'b1;
    end else if (word_hit(adr_i, ufc_pkg::OFS_CTRL1)) begin
      selCtrl1 = 1'b1;
    end
  end

  // per-channel control write strobe, true only on the ack edge
  always_comb begin
    ctlWr[0] = 1'b0;
    ctlWr[1] = 1'b0;
    if (wrDone && wrLane) begin
      if (selCtrl0) begin
        ctlWr[0] = 1'b1;
      end else if (selCtrl1) begin
        ctlWr[1] = 1'b1;
      end
    end
  end

  // read data mux
  always_comb begin
    next_dat = 32'h0000_0000;
    if (word_hit(adr_i, ufc_pkg::OFS_CTRL0)) begin
      next_dat[7:0] = ctrl_byte(fifoEn[0], dmaSel[0], rxTrig[0],
                                txTrig[0], txClr[0], rxClr[0]);
    end else if (word_hit(adr_i, ufc_pkg::OFS_CTRL1)) begin
      next_dat[7:0] = ctrl_byte(fifoEn[1], dmaSel[1], rxTrig[1],
                                txTrig[1], txClr[1], rxClr[1]);
    end else if (word_hit(adr_i, ufc_pkg::OFS_STAT0)) begin
      next_dat = stat_word(rxRdyN[0], txRdyN[0], rxHit[0], txBelow[0],
                           rxRoom[0], rxCnt[0], txCnt[0]);
    end else if (word_hit(adr_i, ufc_pkg::OFS_STAT1)) begin
      next_dat = stat_word(rxRdyN[1], txRdyN[1], rxHit[1], txBelow[1],
                           rxRoom[1], rxCnt[1], txCnt[1]);
    end
  end

  // single-cycle acknowledge, dropped the cycle after
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ack_o <= 1'b0;
    end else if (ce) begin
      ack_o <= busReq & ~ack_o;
    end
  end

  // read data captured together with ack
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dat_o <= 32'h0000_0000;
    end else if (ce) begin
      if (busReq & ~ack_o & ~we_i) begin
        dat_o <= next_dat;
      end
    end
  end

  // persistent control fields, one set per channel
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < 2; c++) begin
        fifoEn[c] <= ufc_pkg::CTL_RESET[ufc_pkg::CTL_FIFOEN];
        dmaSel[c] <= ufc_pkg::CTL_RESET[ufc_pkg::CTL_DMA];
        rxTrig[c] <= ufc_pkg::CTL_RESET[ufc_pkg::CTL_RXTRIG_HI:
                                        ufc_pkg::CTL_RXTRIG_LO];
        txTrig[c] <= ufc_pkg::CTL_RESET[ufc_pkg::CTL_TXTRIG_HI:
                                        ufc_pkg::CTL_TXTRIG_LO];
      end
    end else if (ce) begin
      for (int c = 0; c < 2; c++) begin
        if (ctlWr[c]) begin
          fifoEn[c] <= wrByte[ufc_pkg::CTL_FIFOEN];
          if (wrByte[ufc_pkg::CTL_FIFOEN]) begin
            dmaSel[c] <= wrByte[ufc_pkg::CTL_DMA];
            rxTrig[c] <= wrByte[ufc_pkg::CTL_RXTRIG_HI:
                                ufc_pkg::CTL_RXTRIG_LO];
            txTrig[c] <= wrByte[ufc_pkg::CTL_TXTRIG_HI:
                                ufc_pkg::CTL_TXTRIG_LO];
          end
        end
      end
    end
  end

  // self-clearing fifo clear strobes, high for one cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < 2; c++) begin
        txClr[c] <= 1'b0;
        rxClr[c] <= 1'b0;
      end
    end else if (ce) begin
      for (int c = 0; c < 2; c++) begin
        if (ctlWr[c] && wrByte[ufc_pkg::CTL_FIFOEN]) begin
          txClr[c] <= wrByte[ufc_pkg::CTL_TXCLR];
          rxClr[c] <= wrByte[ufc_pkg::CTL_RXCLR];
        end else begin
          txClr[c] <= 1'b0;
          rxClr[c] <= 1'b0;
        end
      end
    end
  end

  // drive the control outputs straight from the flops
  assign fifoEnable0  = fifoEn[0];
  assign fifoEnable1  = fifoEn[1];
  assign txFifoClear0 = txClr[0];
  assign txFifoClear1 = txClr[1];
  assign rxFifoClear0 = rxClr[0];
  assign rxFifoClear1 = rxClr[1];

  // gather occupancy for status reads
  assign rxCnt[0] = rxCount0;
  assign rxCnt[1] = rxCount1;
  assign txCnt[0] = txCount0;
  assign txCnt[1] = txCount1;

  // channel 0 ready and trigger logic
  ufc_channel #(
    .CW    (CW),
    .DEPTH (DEPTH)
  ) u_chan0 (
    .mclk        (mclk),
    .rst_b       (rst_b),
    .ce          (ce),
    .fifoEnable  (fifoEn[0]),
    .dmaMode     (dmaSel[0]),
    .rxTrigSel   (rxTrig[0]),
    .txTrigSel   (txTrig[0]),
    .rxCount     (rxCount0),
    .txCount     (txCount0),
    .rxTimeout   (rxTimeout0),
    .txReadyN    (txRdyN[0]),
    .rxReadyN    (rxRdyN[0]),
    .rxTrigHit   (rxHit[0]),
    .txBelowTrig (txBelow[0]),
    .rxSpace     (rxRoom[0])
  );

  // channel 1 ready and trigger logic
  ufc_channel #(
    .CW    (CW),
    .DEPTH (DEPTH)
  ) u_chan1 (
    .mclk        (mclk),
    .rst_b       (rst_b),
    .ce          (ce),
    .fifoEnable  (fifoEn[1]),
    .dmaMode     (dmaSel[1]),
    .rxTrigSel   (rxTrig[1]),
    .txTrigSel   (txTrig[1]),
    .rxCount     (rxCount1),
    .txCount     (txCount1),
    .rxTimeout   (rxTimeout1),
    .txReadyN    (txRdyN[1]),
    .rxReadyN    (rxRdyN[1]),
    .rxTrigHit   (rxHit[1]),
    .txBelowTrig (txBelow[1]),
    .rxSpace     (rxRoom[1])
  );

  // channel results onto the top ports
  assign txReadyN0    = txRdyN[0];
  assign rxReadyN0    = rxRdyN[0];
  assign rxTrigHit0   = rxHit[0];
  assign txBelowTrig0 = txBelow[0];
  assign rxSpace0     = rxRoom[0];
  assign txReadyN1    = txRdyN[1];
  assign rxReadyN1    = rxRdyN[1];
  assign rxTrigHit1   = rxHit[1];
  assign txBelowTrig1 = txBelow[1];
  assign rxSpace1     = rxRoom[1];

endmodule

`default_nettype wire

// ---- ufc_properties.sv ----
// Purpose: concurrent checks on the ports of the FIFO control block
// Assumes: one clock domain, ce held high by the bench
// Notes:   attached to ufc_top by a bind in the bench top file
`timescale 1ns/1ps
`default_nettype none
module ufc_properties #(
  parameter int CW = 6
) (
  input wire logic          mclk,
  input wire logic          rst_b,
  input wire logic          ce,
  input wire logic          cyc_i,
  input wire logic          stb_i,
  input wire logic          we_i,
  input wire logic [3:0]    adr_i,
  input wire logic [3:0]    sel_i,
  input wire logic [31:0]   dat_i,
  input wire logic          ack_o,
  input wire logic [CW-1:0] rxCount0,
  input wire logic [CW-1:0] txCount0,
  input wire logic [CW-1:0] rxCount1,
  input wire logic [CW-1:0] txCount1,
  input wire logic          txReadyN0,
  input wire logic          rxReadyN0,
  input wire logic          txReadyN1,
  input wire logic          rxReadyN1,
  input wire logic          fifoEnable0,
  input wire logic          txFifoClear0,
  input wire logic          rxFifoClear0
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // control write to channel 0 at its ack edge
  sequence wrCtl0;
    cyc_i && stb_i && we_i && ack_o && sel_i[0] && adr_i[3:2] == 2'h0;
  endsequence
  // single-cycle pulse
  sequence pulseOnce(logic s);
    s ##1 !s;
  endsequence
  ack_once_a:
    assert property (ack_o && ce |=> !ack_o) else $error("ack too long");
  ack_answer_a:
    assert property (cyc_i && stb_i && !ack_o && ce |=> ack_o)
      else $error("ack missing");
  tx_clear_a:
    assert property (wrCtl0 ##0 (dat_i[2] && dat_i[0]) |=>
      pulseOnce(txFifoClear0)) else $error("tx clear pulse wrong");
  rx_clear_a:
    assert property (wrCtl0 ##0 (dat_i[1] && dat_i[0]) |=>
      pulseOnce(rxFifoClear0)) else $error("rx clear pulse wrong");
  disable_write_a:
    assert property (wrCtl0 ##0 !dat_i[0] |=> !fifoEnable0 &&
      !txFifoClear0 && !rxFifoClear0) else $error("disable write wrong");
  idle_tx_a:
    assert property (!fifoEnable0 |=>
      txReadyN0 == ($past(txCount0) != 6'h00)) else $error("tx pin wrong");
  idle_rx_a:
    assert property (!fifoEnable0 |=>
      rxReadyN0 == ($past(rxCount0) == 6'h00)) else $error("rx pin wrong");
  tx_full_a:
    assert property (txCount1 == 6'h20 |=> txReadyN1)
      else $error("tx pin low when full");
  rx_empty_a:
    assert property (rxCount1 == 6'h00 |=> rxReadyN1)
      else $error("rx pin low when empty");
endmodule
`default_nettype wire

// ---- ufc_fifo_model.sv ----
// Purpose: occupancy model of one channel's receive and transmit FIFOs
// Assumes: counts are loaded by the bench, zeroed by the clear pulses
// Notes:   a clear pulse wins over a load in the same cycle
`timescale 1ns/1ps
`default_nettype none
module ufc_fifo_model (
  input  wire logic                      mclk,
  input  wire logic                      rst_b,
  input  wire logic                      load,
  input  wire logic [ufc_pkg::CNT_W-1:0] rxSet,
  input  wire logic [ufc_pkg::CNT_W-1:0] txSet,
  input  wire logic                      rxClear,
  input  wire logic                      txClear,
  output logic      [ufc_pkg::CNT_W-1:0] rxCount,
  output logic      [ufc_pkg::CNT_W-1:0] txCount
);
  // receive occupancy
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b)
      rxCount <= 6'h00;
    else if (rxClear)
      rxCount <= 6'h00;
    else if (load)
      rxCount <= rxSet;
  end
  // transmit occupancy, shifter not modelled
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b)
      txCount <= 6'h00;
    else if (txClear)
      txCount <= 6'h00;
    else if (load)
      txCount <= txSet;
  end
endmodule
`default_nettype wire

// ---- ufc_tb_top.sv ----
// Purpose: self-checking bench for the two-channel FIFO control block
// Assumes: ce and byte lanes held constant, counts from occupancy models
// Notes:   registers reached over classic Wishbone tasks
`timescale 1ns/1ps
`default_nettype none
bind ufc_top ufc_properties #(.CW(CW)) chk (.mclk, .rst_b, .ce, .cyc_i,
  .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .ack_o, .rxCount0, .txCount0,
  .rxCount1, .txCount1, .txReadyN0, .rxReadyN0, .txReadyN1, .rxReadyN1,
  .fifoEnable0, .txFifoClear0, .rxFifoClear0);
module ufc_tb_top;
  logic        mclk, rst_b, cyc, stb, we, ack, txr0, rxr0, txr1, rxr1;
  logic        tc0, rc0, tc1, rc1;
  wire  [3:0]  fl0, fl1;
  logic [1:0]  ld, tmo;
  logic [3:0]  adr;
  logic [5:0]  rxSet, txSet, rxc0, txc0, rxc1, txc1, lr, lt;
  logic [31:0] wdat, rdat, dout;
  int          fails, n_compared;
  ufc_top dut (.mclk, .rst_b, .ce(1'b1), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(dout),
    .ack_o(ack), .rxCount0(rxc0), .txCount0(txc0), .rxTimeout0(tmo[0]),
    .txReadyN0(txr0), .rxReadyN0(rxr0), .rxTrigHit0(fl0[0]),
    .txBelowTrig0(fl0[1]), .rxSpace0(fl0[2]), .fifoEnable0(fl0[3]),
    .txFifoClear0(tc0), .rxFifoClear0(rc0),
    .rxCount1(rxc1), .txCount1(txc1), .rxTimeout1(tmo[1]),
    .txReadyN1(txr1), .rxReadyN1(rxr1), .rxTrigHit1(fl1[0]),
    .txBelowTrig1(fl1[1]), .rxSpace1(fl1[2]), .fifoEnable1(fl1[3]),
    .txFifoClear1(tc1), .rxFifoClear1(rc1));
  ufc_fifo_model m0 (.mclk, .rst_b, .load(ld[0]), .rxSet, .txSet,
    .rxClear(rc0), .txClear(tc0), .rxCount(rxc0), .txCount(txc0));
  ufc_fifo_model m1 (.mclk, .rst_b, .load(ld[1]), .rxSet, .txSet,
    .rxClear(rc1), .txClear(tc1), .rxCount(rxc1), .txCount(txc1));
  // verdict and end of run
  task automatic test_done();
    if (fails == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic bus cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      fails++;
      test_done();
    end else begin
      rdat = dout;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    wb(1'b0, a, 8'h00);
    cmp(rdat, exp);
  endtask
  // load occupancy of one channel, wait for the pins to follow
  task automatic setc(input int ch, input logic [5:0] r, input logic [5:0] t);
    @(posedge mclk);
    rxSet <= r;
    txSet <= t;
    ld[ch] <= 1'b1;
    @(posedge mclk);
    ld <= 2'h0;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // main sequence
  initial begin
    {rst_b, cyc, stb, we, ld, tmo, adr, wdat} = '0;
    {rxSet, txSet, fails, n_compared} = '0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    rd(4'h0, 32'h00);
    rd(4'h8, 32'h11);
    setc(0, 6'h01, 6'h01);
    cmp({31'h0, txr0}, 32'h1);
    cmp({31'h0, rxr0}, 32'h0);
    setc(0, 6'h00, 6'h00);
    cmp({31'h0, txr0}, 32'h0);
    cmp({31'h0, rxr0}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      lr = (i == 0) ? 6'h08 : (i == 1) ? 6'h10 : (i == 2) ? 6'h18 : 6'h1c;
      lt = (i == 0) ? 6'h10 : (i == 1) ? 6'h08 : (i == 2) ? 6'h18 : 6'h1e;
      wb(1'b1, 4'h0, {i[1:0], i[1:0], 4'h1});
      rd(4'h0, {24'h0, i[1:0], i[1:0], 4'h1});
      setc(0, lr - 6'h01, lt);
      cmp({28'h0, fl0}, 32'hc);
      rd(4'h8, {10'h0, lt, 2'h0, lr - 6'h01, 8'h12});
      setc(0, lr, lt - 6'h01);
      cmp({28'h0, fl0}, 32'hf);
      rd(4'h8, {10'h0, lt - 6'h01, 2'h0, lr, 8'h1e});
    end
    wb(1'b1, 4'h0, 8'hf7);
    repeat (2) @(posedge mclk);
    rd(4'h0, 32'hf1);
    rd(4'h8, 32'h19);
    wb(1'b1, 4'h0, 8'h0e);
    rd(4'h0, 32'hf0);
    cmp({28'h0, fl0}, 32'h4);
    wb(1'b1, 4'h0, 8'h01);
    wb(1'b1, 4'h4, 8'h09);
    rd(4'h4, 32'h09);
    rd(4'h0, 32'h01);
    setc(1, 6'h04, 6'h00);
    cmp({31'h0, rxr1}, 32'h1);
    cmp({31'h0, rxr0}, 32'h1);
    @(posedge mclk);
    tmo <= 2'h2;
    @(posedge mclk);
    tmo <= 2'h0;
    repeat (2) @(posedge mclk);
    #1;
    cmp({31'h0, rxr1}, 32'h0);
    setc(1, 6'h02, 6'h00);
    cmp({31'h0, rxr1}, 32'h0);
    setc(1, 6'h00, 6'h00);
    cmp({31'h0, rxr1}, 32'h1);
    setc(1, 6'h08, 6'h20);
    cmp({31'h0, rxr1}, 32'h0);
    cmp({31'h0, txr1}, 32'h1);
    cmp({31'h0, txr0}, 32'h0);
    setc(1, 6'h08, 6'h14);
    cmp({31'h0, txr1}, 32'h1);
    setc(1, 6'h08, 6'h10);
    cmp({31'h0, txr1}, 32'h0);
    setc(1, 6'h08, 6'h14);
    cmp({31'h0, txr1}, 32'h0);
    setc(1, 6'h20, 6'h20);
    cmp({28'h0, fl1}, 32'h9);
    rd(4'hc, 32'h0020_2006);
    wb(1'b1, 4'h4, 8'h0f);
    repeat (3) @(posedge mclk);
    #1;
    cmp({31'h0, txr1}, 32'h0);
    cmp({31'h0, rxr1}, 32'h1);
    cmp({28'h0, fl1}, 32'he);
    rd(4'h4, 32'h09);
    test_done();
  end
endmodule
`default_nettype wire
